// >>> core/jtp_debug_port.sv
/*
  Test access port with instruction and data registers, debug gate,
  breakpoint mode register, CPU byte channel and AHB-Lite register slave.
  Assumes the four port pins arrive asynchronously and an external pad
  ring resolves pinOut/pinOe/pinPullUp into the wires.
*/
//
// Summary of operation
// - sixteen-state controller stepped on test clock rise
// - controller starts in reset state after power-on
// - no test reset pin exists
// - fuse unprogrammed: pins are general purpose, held
// - enabled port pulls pins high internally
// - every shift register shifts LSB first
// - instruction shift outputs captured pattern 0x01
// - instruction takes effect only in update state
// - data shift outputs values captured earlier
// - latched data outputs change only in update, except access enable clearing on gate close
// - five high mode-select rises reach reset state
// - opcodes 0x8 to 0xB reach debug system
// - debug needs fuse and both lock bits clear
// - four breakpoint resources in five modes
// - CPU write stores byte and sets dirty
// - CPU read: seven data bits, dirty on top
// - shared address reaches channel only when allowed
// - reset state selects identity read instruction
`timescale 1ns/1ns
`default_nettype none
module jtp_debug_port
  import jtp_pkg::*;
#(
  // identity fields; values are arbitrary
  parameter logic [3:0] ID_VERSION = 4'h0,
  parameter logic [15:0] ID_PART = 16'h0000,
  parameter logic [10:0] ID_MAKER = 11'h000
)
(
  input wire logic mclk,
  input wire logic rst_n,
  // fuses and lock bits, static from the fuse block
  input wire logic testPortEnableFuse,
  input wire logic debugEnableFuse,
  input wire logic lockBitOne,
  input wire logic lockBitTwo,
  // the four port pins
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  output logic [3:0] pinPullUp,
  // debug side effects
  output logic debugActive,
  output logic [3:0] debugOpSel,
  output logic [2:0] bpMode,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ----------------------------------------------------------------
  // shared helper
  // ----------------------------------------------------------------
  // one shift step: drop bit 0, new bit enters at the top of len
  function automatic logic [31:0] shiftIn(input logic [31:0] sr, input logic bitIn,
                                          input logic [5:0] len);
    logic [31:0] v;
    v = sr >> 1;
    v[5'(len - 6'd1)] = bitIn;
    return v;
  endfunction : shiftIn

  // ----------------------------------------------------------------
  // pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic tckPrev_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
      tckPrev_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      tckPrev_r <= pinSync_r[PIN_TCK];
    end
  end

  logic softDisable_r;
  wire tapOn = testPortEnableFuse && !softDisable_r;
  wire tapHold = !tapOn; // no other reset source
  wire tckRise = tapOn && pinSync_r[PIN_TCK] && !tckPrev_r;
  wire tckFall = tapOn && !pinSync_r[PIN_TCK] && tckPrev_r;
  wire tms = pinSync_r[PIN_TMS];
  wire tdi = pinSync_r[PIN_TDI];

  jtp_state_e state;
  jtp_tap_fsm u_fsm (
    .mclk(mclk),
    .rst_n(rst_n),
    .hold(tapHold),
    .tckRise(tckRise),
    .tms(tms),
    .state(state)
  );

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [3:0] irSr_r;
  logic [3:0] ir_r;
  wire [31:0] irShifted = shiftIn({28'h0, irSr_r}, tdi, 6'(IR_W));
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irSr_r <= IR_CAPTURE;
      ir_r <= OP_IDCODE;
    end
    else if (state == TLR)
      ir_r <= OP_IDCODE;
    else if (tckRise && state == CAP_IR)
      irSr_r <= IR_CAPTURE;
    else if (tckRise && state == SH_IR)
      irSr_r <= irShifted[3:0];
    else if (tckFall && state == UPD_IR)
      ir_r <= irSr_r;
  end

  // ----------------------------------------------------------------
  // debug gate and data register selection
  // ----------------------------------------------------------------
  wire dbgGate = tapOn && debugEnableFuse && !lockBitOne && !lockBitTwo;
  wire selId = ir_r == OP_IDCODE;
  wire selChan = dbgGate && ir_r == OP_RSV_A;
  wire selAcc = dbgGate && ir_r == OP_RSV_B;
  wire selBpm = dbgGate && ir_r == OP_RSV_C;
  // the fourth reserved op has no data register here and falls back to bypass
  wire [5:0] drLen = selId ? LEN_ID : selChan ? LEN_CHAN : selAcc ? LEN_ACC : selBpm ? LEN_BPM : LEN_BYP;

  logic dirty_r;
  logic [7:0] chan_r;
  logic accessEn_r;
  logic [2:0] bpMode_r;
  wire [31:0] drCapture = selId ? {ID_VERSION, ID_PART, ID_MAKER, 1'b1} :
                          selChan ? {23'h0, dirty_r, chan_r} :
                          selAcc ? {31'h0, accessEn_r} :
                          selBpm ? {29'h0, bpMode_r} : 32'h0;

  logic [31:0] drSr_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      drSr_r <= 32'h0000_0000;
    else if (tckRise && state == CAP_DR)
      drSr_r <= drCapture;
    else if (tckRise && state == SH_DR)
      drSr_r <= shiftIn(drSr_r, tdi, drLen);
  end

  wire updDr = tckFall && state == UPD_DR;
  // a mode outside the five legal combinations is ignored
  wire bpmLegal = drSr_r[2:0] <= BPM_LAST;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accessEn_r <= 1'b0;
      bpMode_r <= BPM_RESET;
    end
    else if (!dbgGate)
      accessEn_r <= 1'b0;
    else if (updDr && selAcc)
      accessEn_r <= drSr_r[0];
    else if (updDr && selBpm && bpmLegal)
      bpMode_r <= drSr_r[2:0];
  end

  // ----------------------------------------------------------------
  // serial output and pins
  // ----------------------------------------------------------------
  wire isShift = state == SH_IR || state == SH_DR;
  wire tdoBit = (state == SH_IR) ? irSr_r[0] : drSr_r[0];
  logic tdo_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tdo_r <= 1'b0;
    else if (tckFall)
      tdo_r <= isShift ? tdoBit : 1'b0;
  end

  logic [3:0] gpioOut_r;
  logic [3:0] gpioOe_r;
  wire [3:0] testOe = {isShift, 3'b000};
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut <= 4'h0;
      pinOe <= 4'h0;
      pinPullUp <= 4'h0;
    end
    else
    begin
      pinOut <= tapOn ? {tdo_r, 3'b000} : gpioOut_r;
      pinOe <= tapOn ? testOe : gpioOe_r;
      pinPullUp <= {4{tapOn}};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      debugActive <= 1'b0;
      debugOpSel <= 4'h0;
      bpMode <= BPM_RESET;
    end
    else
    begin
      debugActive <= dbgGate;
      debugOpSel <= dbgGate ? {ir_r == OP_RSV_D, selBpm, selAcc, selChan} : 4'h0;
      bpMode <= bpMode_r;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] ofs = haddr[7:0];
  wire chanOpen = debugEnableFuse && accessEn_r;
  logic wrPend_r;
  logic [7:0] wrOfs_r;
  logic [7:0] plainIo_r;
  wire wrChan = wrPend_r && wrOfs_r == OFS_CHAN && chanOpen;
  wire wrPlain = wrPend_r && wrOfs_r == OFS_CHAN && !chanOpen;
  wire [31:0] statusWord = {18'h0, accessEn_r, dbgGate, dirty_r, bpMode_r, ir_r, 4'(state)};
  wire [31:0] readMux = (ofs == OFS_CTRL) ? {31'h0, softDisable_r} :
                        (ofs == OFS_CHAN) ? (chanOpen ? {24'h0, dirty_r, chan_r[6:0]} : {24'h0, plainIo_r}) :
                        (ofs == OFS_STATUS) ? statusWord :
                        (ofs == OFS_PINS) ? {20'h0, pinSync_r, gpioOe_r, gpioOut_r} : 32'h0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      wrOfs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wrPend_r <= addrPhase && hwrite;
      wrOfs_r <= ofs;
      hrdata <= (addrPhase && !hwrite) ? readMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      softDisable_r <= 1'b0;
      gpioOut_r <= 4'h0;
      gpioOe_r <= 4'h0;
      plainIo_r <= CHAN_RESET;
      chan_r <= CHAN_RESET;
    end
    else
    begin
      if (wrPend_r && wrOfs_r == OFS_CTRL)
        softDisable_r <= hwdata[CTRL_SOFTDIS_BIT];
      if (wrPend_r && wrOfs_r == OFS_PINS)
      begin
        gpioOut_r <= hwdata[3:0];
        gpioOe_r <= hwdata[7:4];
      end
      if (wrPlain)
        plainIo_r <= hwdata[7:0];
      if (wrChan)
        chan_r <= hwdata[7:0];
    end
  end

  // cpu set wins over a debugger clear in the same cycle
  wire dbgClear = updDr && selChan && drSr_r[8];
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dirty_r <= 1'b0;
    else if (wrChan)
      dirty_r <= 1'b1;
    else if (dbgClear)
      dirty_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] tmsHighCnt_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tmsHighCnt_r <= 3'h0;
    else if (tckRise)
      tmsHighCnt_r <= !tms ? 3'h0 : (tmsHighCnt_r == 3'(TLR_TMS_COUNT) ? tmsHighCnt_r : tmsHighCnt_r + 3'h1);
  end

  tlr_after_five_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tmsHighCnt_r == 3'd5 |-> state == TLR)
    else $error("five high mode-select rises did not reach reset state");

  hold_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tapHold |=> state == TLR && pinPullUp == 4'h0)
    else $error("disabled port not held in reset");

  ir_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tckRise && state == CAP_IR |=> irSr_r == 4'h1 ##0 state != CAP_IR)
    else $error("instruction capture pattern wrong");

  ir_update_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(ir_r) |-> $past(state) == UPD_IR || $past(state) == TLR)
    else $error("instruction changed outside update");

  tdo_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pinOe[3] && $past(tapOn) |-> $past(isShift))
    else $error("serial output driven outside shift");

  dr_update_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(bpMode_r) |-> $past(state) == UPD_DR && $past(bpMode_r) != bpMode_r)
    else $error("latched data output changed outside update");

  dirty_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wrChan |=> dirty_r && chan_r == $past(hwdata[7:0]))
    else $error("channel write did not set dirty");

  chan_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    addrPhase && !hwrite && ofs == OFS_CHAN && chanOpen |=> hrdata[7] == $past(dirty_r)
      && hrdata[6:0] == $past(chan_r[6:0]))
    else $error("channel read layout wrong");

  debug_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    debugActive |-> $past(debugEnableFuse && !lockBitOne && !lockBitTwo))
    else $error("debug active while fused off or locked");

  pullup_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n && testPortEnableFuse && !softDisable_r |=> pinPullUp == 4'hF)
    else $error("enabled port pins not pulled high");

endmodule : jtp_debug_port
`default_nettype wire

// >>> core/jtp_pkg.sv
/*
  Shared constants and types for the four-wire test access port with its
  debug gate, breakpoint mode register and CPU-to-debugger byte channel.
  Assumes one system clock domain; the test clock is a sampled pin.
*/
package jtp_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jtp_state_e;

  // ----------------------------------------------------------------
  // instruction codes and widths
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_BYPASS = 4'hF;
  localparam logic [3:0] OP_RSV_A = 4'h8;
  localparam logic [3:0] OP_RSV_B = 4'h9;
  localparam logic [3:0] OP_RSV_C = 4'hA;
  localparam logic [3:0] OP_RSV_D = 4'hB;

  // data register lengths
  localparam logic [5:0] LEN_ID = 6'd32;
  localparam logic [5:0] LEN_BYP = 6'd1;
  localparam logic [5:0] LEN_CHAN = 6'd9;
  localparam logic [5:0] LEN_ACC = 6'd1;
  localparam logic [5:0] LEN_BPM = 6'd3;

  // breakpoint resource modes; codes above the last are refused
  localparam logic [2:0] BPM_LAST = 3'h4;
  localparam logic [2:0] BPM_RESET = 3'h0;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PINS = 8'h0C;

  localparam logic [7:0] CHAN_RESET = 8'h00;
  localparam int CTRL_SOFTDIS_BIT = 0;

  // pin positions within the four-pin group
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;

  localparam int TLR_TMS_COUNT = 5;

endpackage : jtp_pkg

// >>> core/jtp_tap_fsm.sv
/*
  Sixteen-state test controller, stepped once per sampled test clock
  rising edge. Assumes tckRise is a one-cycle pulse in the mclk domain and
  tms is already synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
module jtp_tap_fsm
  import jtp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic tckRise,
  input wire logic tms,
  output var jtp_state_e state
);

  jtp_state_e state_nxt;
  jtp_state_e stepped;

  always_comb
  begin
    case (state)
      TLR: stepped = tms ? TLR : RTI;
      RTI: stepped = tms ? SEL_DR : RTI;
      SEL_DR: stepped = tms ? SEL_IR : CAP_DR;
      CAP_DR: stepped = tms ? EX1_DR : SH_DR;
      SH_DR: stepped = tms ? EX1_DR : SH_DR;
      EX1_DR: stepped = tms ? UPD_DR : PAU_DR;
      PAU_DR: stepped = tms ? EX2_DR : PAU_DR;
      EX2_DR: stepped = tms ? UPD_DR : SH_DR;
      UPD_DR: stepped = tms ? SEL_DR : RTI;
      SEL_IR: stepped = tms ? TLR : CAP_IR;
      CAP_IR: stepped = tms ? EX1_IR : SH_IR;
      SH_IR: stepped = tms ? EX1_IR : SH_IR;
      EX1_IR: stepped = tms ? UPD_IR : PAU_IR;
      PAU_IR: stepped = tms ? EX2_IR : PAU_IR;
      EX2_IR: stepped = tms ? UPD_IR : SH_IR;
      UPD_IR: stepped = tms ? SEL_DR : RTI;
      default: stepped = TLR;
    endcase
  end

  // state only moves on a test clock rise; hold forces reset
  assign state_nxt = hold ? TLR : (tckRise ? stepped : state);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= TLR;
    else
      state <= state_nxt;
  end

  fsm_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(state) |-> $past(tckRise) || $past(hold))
    else $error("controller moved without a test clock rise");

endmodule : jtp_tap_fsm
`default_nettype wire

// >>> dv/jtp_tester_model.sv
/*
  Behavioural tester probe for the four-wire test port: steps the test
  clock, mode select and serial input from mclk edges, samples serial out.
  Assumes a 250 MHz mclk; one test clock period is 16 mclk (64 ns).
*/
`timescale 1ns/1ns
`default_nettype none
module jtp_tester_model
  import jtp_pkg::*;
(
  input wire logic mclk,
  input wire logic tdo,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // link steps
  // ----------------------------------------------------------------
  // clock stands low between steps; serial out read at end of low phase
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge mclk);
    q = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge mclk);
    tck <= 1'b0;
  endtask : step

  // unused serial input flips so a stale bit cannot pass for data
  task automatic nav(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask : nav

  // lets the falling-edge update land before the bench looks
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask : settle

  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    settle();
  endtask : shift

  task automatic irShift(input logic [3:0] op, output logic [3:0] cap);
    logic [31:0] q;
    nav(1'b1);
    nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    shift(IR_W, {28'h0, op}, q);
    cap = q[3:0];
  endtask : irShift

  task automatic drShift(input int n, input logic [31:0] din, output logic [31:0] dout);
    nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    shift(n, din, dout);
  endtask : drShift

  task automatic finish();
    nav(1'b1);
    nav(1'b0);
    settle();
  endtask : finish
endmodule : jtp_tester_model
`default_nettype wire

// >>> dv/jtp_debug_port_test.sv
/*
  Self-checking bench for the test access port: link scans through the
  tester model, register access over AHB-Lite, fuse and lock gating.
  Assumes a zero-wait slave whose hreadyout is also the bus hready.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); end end
module jtp_debug_port_test
  import jtp_pkg::*;
;
  // identity fields; values are arbitrary
  localparam logic [3:0] ID_VER = 4'h3;
  localparam logic [15:0] ID_PRT = 16'h5A3C;
  localparam logic [10:0] ID_MKR = 11'h2B5;
  logic mclk, rst_n, testPortEnableFuse, debugEnableFuse, lockBitOne, lockBitTwo;
  logic [3:0] pinIn, pinOut, pinOe, pinPullUp, debugOpSel;
  logic [2:0] bpMode, hsize;
  logic debugActive, hsel, hwrite, hreadyout, hresp, tck, tms, tdi;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int bad_count, compares;

  // pad ring: pin shows driver if enabled, else tester (pins 0-2), or pull level or inverted driver value (pin 3)
  assign pinIn[0] = pinOe[0] ? pinOut[0] : tck;
  assign pinIn[1] = pinOe[1] ? pinOut[1] : tms;
  assign pinIn[2] = pinOe[2] ? pinOut[2] : tdi;
  assign pinIn[3] = pinOe[3] ? pinOut[3] : (pinPullUp[3] ? 1'b1 : ~pinOut[3]);

  jtp_debug_port #(.ID_VERSION(ID_VER), .ID_PART(ID_PRT), .ID_MAKER(ID_MKR)) jtp_debug_port_i (
    .mclk(mclk), .rst_n(rst_n), .testPortEnableFuse(testPortEnableFuse),
    .debugEnableFuse(debugEnableFuse), .lockBitOne(lockBitOne), .lockBitTwo(lockBitTwo),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
    .debugActive(debugActive), .debugOpSel(debugOpSel), .bpMode(bpMode),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  jtp_tester_model jtp_tester_model_i (.mclk(mclk), .tdo(pinIn[3]), .tck(tck), .tms(tms), .tdi(tdi));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      bad_count++;
      give_verdict();
    end
  endtask : waitReady

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask : rd

  // {port fuse, debug fuse, lock one, lock two} in one step
  task automatic setFuses(input logic [3:0] f);
    {testPortEnableFuse, debugEnableFuse, lockBitOne, lockBitTwo} <= f;
  endtask : setFuses

  task automatic load(input logic [3:0] op);
    logic [3:0] c;
    jtp_tester_model_i.irShift(op, c);
    `CHK(c, IR_CAPTURE)
    jtp_tester_model_i.finish();
  endtask : load

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic checkReset();
    logic [31:0] q;
    `CHK(pinPullUp, 4'hF)
    `CHK(debugActive, 1'b1)
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_IDCODE, 4'(TLR)})
    rd(8'h10, q);
    `CHK(q, 32'h0)
    `CHK(hresp, 1'b0)
  endtask : checkReset

  task automatic checkIdScan();
    logic [31:0] q;
    jtp_tester_model_i.nav(1'b0);
    jtp_tester_model_i.drShift(32, 32'h0, q);
    jtp_tester_model_i.finish();
    `CHK(q, {ID_VER, ID_PRT, ID_MKR, 1'b1})
    `CHK(pinOe[3], 1'b0)
  endtask : checkIdScan

  task automatic checkIrUpdate();
    logic [3:0] c;
    logic [31:0] q;
    jtp_tester_model_i.irShift(OP_BYPASS, c);
    `CHK(c, IR_CAPTURE)
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_IDCODE, 4'(EX1_IR)})
    jtp_tester_model_i.finish();
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_BYPASS, 4'(RTI)})
    jtp_tester_model_i.drShift(8, 32'hA5, q);
    jtp_tester_model_i.finish();
    `CHK(q[7:0], 8'h4A)
  endtask : checkIrUpdate

  task automatic checkFiveOnes();
    logic [31:0] q;
    jtp_tester_model_i.nav(1'b1);
    jtp_tester_model_i.nav(1'b0);
    jtp_tester_model_i.nav(1'b0);
    repeat (4) jtp_tester_model_i.nav(1'b1);
    jtp_tester_model_i.settle();
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_BYPASS, 4'(SEL_IR)})
    jtp_tester_model_i.nav(1'b1);
    jtp_tester_model_i.settle();
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_IDCODE, 4'(TLR)})
    jtp_tester_model_i.nav(1'b0);
  endtask : checkFiveOnes

  task automatic checkDebugGate();
    for (int k = 0; k < 4; k++)
    begin
      load(OP_RSV_A + 4'(k));
      `CHK(debugOpSel, 4'b0001 << k)
    end
    setFuses(4'b1110);
    jtp_tester_model_i.settle();
    `CHK({debugActive, debugOpSel}, 5'h00)
    setFuses(4'b1101);
    jtp_tester_model_i.settle();
    `CHK(debugActive, 1'b0)
    setFuses(4'b1000);
    jtp_tester_model_i.settle();
    `CHK(debugActive, 1'b0)
    setFuses(4'b1100);
    jtp_tester_model_i.settle();
    `CHK(debugActive, 1'b1)
  endtask : checkDebugGate

  task automatic checkChannel();
    logic [31:0] q;
    wr(OFS_CHAN, 32'hC5);
    rd(OFS_CHAN, q);
    `CHK(q, 32'hC5)
    load(OP_RSV_B);
    jtp_tester_model_i.drShift(1, 32'h1, q);
    jtp_tester_model_i.finish();
    wr(OFS_CHAN, 32'h3A);
    rd(OFS_CHAN, q);
    `CHK(q, 32'hBA)
    load(OP_RSV_A);
    jtp_tester_model_i.drShift(9, 32'h13A, q);
    jtp_tester_model_i.finish();
    `CHK(q[8:0], 9'h13A)
    rd(OFS_CHAN, q);
    `CHK(q, 32'h3A)
  endtask : checkChannel

  task automatic checkBreakMode();
    logic [31:0] q;
    load(OP_RSV_C);
    jtp_tester_model_i.drShift(3, 32'h4, q);
    `CHK(bpMode, BPM_RESET)
    jtp_tester_model_i.finish();
    `CHK(bpMode, 3'h4)
    jtp_tester_model_i.drShift(3, 32'h5, q);
    `CHK(q[2:0], 3'h4)
    jtp_tester_model_i.finish();
    `CHK(bpMode, 3'h4)
  endtask : checkBreakMode

  task automatic checkDisable();
    logic [31:0] q;
    wr(OFS_PINS, 32'hE5);
    wr(OFS_CTRL, 32'h1);
    jtp_tester_model_i.settle();
    `CHK({pinPullUp, pinOe, pinOut}, 12'h0E5)
    wr(OFS_CTRL, 32'h0);
    setFuses(4'b0100);
    jtp_tester_model_i.nav(1'b0);
    jtp_tester_model_i.settle();
    `CHK({pinPullUp, pinOe, pinOut, debugActive}, 13'h01CA)
    rd(OFS_STATUS, q);
    `CHK(q[3:0], 4'(TLR))
    setFuses(4'b1100);
    wr(OFS_PINS, 32'h0);
    jtp_tester_model_i.settle();
    `CHK({pinPullUp, pinOe[3]}, 5'h1E)
  endtask : checkDisable

  task automatic checkSecondReset();
    logic [31:0] q;
    jtp_tester_model_i.nav(1'b0);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(OFS_STATUS, q);
    `CHK(q[7:0], {OP_IDCODE, 4'(TLR)})
    `CHK(bpMode, BPM_RESET)
  endtask : checkSecondReset

  // watchdog against a hung wait
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    bad_count = 0;
    compares = 0;
    rst_n = 1'b0;
    setFuses(4'b1100);
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    checkReset();
    checkIdScan();
    checkIrUpdate();
    checkFiveOnes();
    checkDebugGate();
    checkChannel();
    checkBreakMode();
    checkDisable();
    checkSecondReset();
    give_verdict();
  end
endmodule : jtp_debug_port_test
`default_nettype wire
